//--- crg_defines.svh
// Constants for the core working registers and operand addressing block.
// Assumes it is included by bare name wherever these numbers are needed.
`ifndef CRG_DEFINES_SVH
`define CRG_DEFINES_SVH

// Special register addresses inside the upper direct space.
`define CRG_ADR_SP        8'h81
`define CRG_ADR_DPL       8'h82
`define CRG_ADR_DPH       8'h83
`define CRG_ADR_PSW       8'hD0
`define CRG_ADR_ACC       8'hE0
`define CRG_ADR_B         8'hF0
`define CRG_SFR_BASE      8'h80
// Reset values.
`define CRG_SP_RST        8'h07
`define CRG_DPL_RST       8'h00
`define CRG_DPH_RST       8'h00
`define CRG_PSW_RST       7'h00
`define CRG_ACC_RST       8'h00
`define CRG_B_RST         8'h00
`define CRG_PC_RST        16'h0000
// Status word fields, bit numbers of the stored upper seven bits.
`define CRG_PSW_CY        6
`define CRG_PSW_RS_HI     3
`define CRG_PSW_RS_LO     2
// First byte of bit-addressable data RAM, upper nibble.
`define CRG_BIT_RAM_HI    4'h2
// Command opcodes.
`define CRG_OPC_IDLE      8'h00
`define CRG_OPC_MOV_A_IMM 8'h01
`define CRG_OPC_ADD_IMM   8'h02
`define CRG_OPC_SUB_IMM   8'h03
`define CRG_OPC_MOV_A_RN  8'h04
`define CRG_OPC_MOV_RN_A  8'h05
`define CRG_OPC_MOV_A_IND 8'h06
`define CRG_OPC_MOV_IND_A 8'h07
`define CRG_OPC_MOV_A_DIR 8'h08
`define CRG_OPC_MOV_DIR_A 8'h09
`define CRG_OPC_SET_BIT   8'h0A
`define CRG_OPC_CLR_BIT   8'h0B
`define CRG_OPC_PUSH      8'h0C
`define CRG_OPC_LOAD_DATA_POINTER_WORD 8'h0D
`define CRG_OPC_SHORT_JMP 8'h0E
`define CRG_OPC_JMP_CARRY 8'h0F
`define CRG_OPC_PAGE_JMP  8'h10
`define CRG_OPC_LONG_JMP  8'h11
`define CRG_OPC_UNUSED    8'hA5

`endif

//--- crg_pkg.sv
// Types shared by the core register block and its users.
// Assumes crg_defines.svh sits in the same folder.
`include "crg_defines.svh"

package crg_pkg;

   // Command from the sequencer: opcode, two operand bytes, length in bytes.
   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] arg1;
      logic [7:0] arg2;
      logic [1:0] len;
   } crg_cmd_type;

   // Architectural state shown to the rest of the core.
   typedef struct packed {
      logic [15:0] pc;
      logic [15:0] data_pointer_word;
      logic [7:0]  sp;
      logic [7:0]  acc;
      logic [7:0]  program_status_word;
   } crg_state_type;

   // One byte write into the direct space or into data RAM.
   typedef struct packed {
      logic       en;
      logic       ram;
      logic [7:0] adr;
      logic [7:0] dat;
   } crg_wport_type;

endpackage

//--- crg_core_regs.sv
// Core working registers, data RAM and operand address resolution.
// Assumes one clock, a synchronous reset and a classic Wishbone master.
//
// Functional notes
// - Banked operand picks R0-R7 of selected bank.
// - Indirect operand addresses RAM through R0 or R1.
// - Relative target is next address plus signed byte.
// - Direct below 0x80 is RAM, above SFR.
// - Immediates are one byte, pointer load two.
// - Bit operand hits RAM or SFR bit.
// - Page target stays in next instruction's page.
// - Long target is a full sixteen-bit address.
// - Unused opcode behaves as idle operation.
// - Pointer low byte, read-write, resets zero.
// - Pointer high byte, read-write, resets zero.
// - Stack pointer increments before each store.
// - Stack pointer resets to seven.
// - Accumulator is read-write, bit-addressable, resets zero.
// - Second accumulator read-write, bit-addressable, resets zero.
// - Status word resets zero, lowest bit read-only.
// - Carry follows add carry or subtract borrow.
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "crg_defines.svh"

module crg_core_regs #(
   parameter int RAM_DEPTH = 256             // Data RAM bytes reachable indirectly.
) (
   input  wire logic                 mclk_i,    // Core clock, 125 MHz.
   input  wire logic                 rst_i,     // Synchronous reset, active high.
   input  wire logic                 wb_cyc_i,  // Wishbone cycle.
   input  wire logic                 wb_stb_i,  // Wishbone strobe.
   input  wire logic                 wb_we_i,   // Wishbone write enable.
   input  wire logic [9:0]           wb_adr_i,  // Byte address, word index in [9:2].
   input  wire logic [3:0]           wb_sel_i,  // Byte enables, lane 0 carries data.
   input  wire logic [31:0]          wb_dat_i,  // Write data.
   output logic      [31:0]          wb_dat_o,  // Read data.
   output logic                      wb_ack_o,  // Acknowledge.
   input  wire logic                 cmd_valid_i, // Sequencer offers a command.
   input  wire crg_pkg::crg_cmd_type cmd_i,     // The command itself.
   output logic                      cmd_ready_o, // Command can be taken this edge.
   output crg_pkg::crg_state_type    state_o    // Registered architectural state.
);

   ////////////////////////////////////////////////////////////////////////////
   // Storage.

   logic [7:0]    ram_q [RAM_DEPTH];   // Data RAM, banks at the bottom.
   logic [7:0]    sp_q;                // Stack top pointer.
   logic [7:0]    dpl_q;               // Data pointer low byte.
   logic [7:0]    dph_q;               // Data pointer high byte.
   logic [7:0]    acc_q;               // Primary working register.
   logic [7:0]    b_q;                 // Second accumulator.
   logic [6:0]    psw_q;               // Status word bits 7 to 1.
   logic [15:0]   pc_q;                // Program counter.
   logic          ack_q;               // Wishbone acknowledge.
   logic [31:0]   rdat_q;              // Wishbone read data.

   logic          parity;              // Odd one count of the accumulator.
   logic          take;                // A command is accepted this edge.
   logic          bus_req;             // Wishbone request present.
   logic          bus_we;              // Bus write lands this edge.
   logic [7:0]    bus_idx;             // Register index from the byte address.
   crg_pkg::crg_wport_type wp;         // The single byte write port.
   logic          carry_en;            // Arithmetic updates the carry.
   logic          carry_val;           // New carry value.
   logic [15:0]   next_pc;             // Address of the following instruction.
   logic [15:0]   target;              // Program counter after the command.
   logic [8:0]    arith;               // Nine-bit add or subtract result.
   logic [7:0]    bit_byte;            // Byte holding the addressed bit.
   logic [7:0]    bit_old;             // Current value of that byte.

   ////////////////////////////////////////////////////////////////////////////
   // Helper functions.

   // Address of a banked register in the bank chosen by the status word.
   function automatic logic [7:0] bank_adr(input logic [1:0] rs, input logic [2:0] n);
      bank_adr = {3'h0, rs, n};
   endfunction

   // Direct-space read: RAM below the special area, registers above it.
   function automatic logic [7:0] rd_direct(input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      if (a < `CRG_SFR_BASE) begin
         v = ram_q[a];
      end else begin
         case (a)
            `CRG_ADR_SP:  v = sp_q;
            `CRG_ADR_DPL: v = dpl_q;
            `CRG_ADR_DPH: v = dph_q;
            `CRG_ADR_PSW: v = {psw_q, parity};
            `CRG_ADR_ACC: v = acc_q;
            `CRG_ADR_B:   v = b_q;
            default:      v = 8'h00;
         endcase
      end
      rd_direct = v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Wishbone slave. The bus wins the write port, so the sequencer is held
   // off for the one cycle in which a bus write lands; reads never stall it.

   assign bus_req     = wb_cyc_i & wb_stb_i;
   assign bus_idx     = wb_adr_i[9:2];
   assign bus_we      = bus_req & wb_we_i & ack_q & wb_sel_i[0];
   assign cmd_ready_o = ~(bus_req & wb_we_i & ack_q);
   assign take        = cmd_valid_i & cmd_ready_o;
   assign wb_ack_o    = ack_q;
   assign wb_dat_o    = rdat_q;

   // Acknowledge one cycle after the request and drop it the cycle after.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= bus_req & ~ack_q;
      end
   end

   // Read data is captured together with the acknowledge; upper bits are zero.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rdat_q <= 32'h0000_0000;
      end else if (bus_req & ~ack_q) begin
         rdat_q <= {24'h00_0000, rd_direct(bus_idx)};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Operand resolution and write port selection.

   assign parity   = ^acc_q;
   // Bits below the split live in the sixteen bytes from 0x20; above it each
   // register on an eight-byte boundary holds eight bits.
   assign bit_byte = cmd_i.arg1[7] ? {cmd_i.arg1[7:3], 3'h0}
                                   : {`CRG_BIT_RAM_HI, cmd_i.arg1[6:3]};

   // Procedural, so the old byte follows the storage and not only the address.
   always_comb begin
      bit_old = rd_direct(bit_byte);
   end

   // One write per cycle: a landing bus write, otherwise the command's write.
   always_comb begin
      wp        = '0;
      carry_en  = 1'b0;
      carry_val = 1'b0;
      arith     = 9'h000;
      if (bus_we) begin
         wp = '{en: 1'b1, ram: ~bus_idx[7], adr: bus_idx, dat: wb_dat_i[7:0]};
      end else if (take) begin
         case (cmd_i.opcode)
            `CRG_OPC_MOV_A_IMM: begin
               wp = '{en: 1'b1, ram: 1'b0, adr: `CRG_ADR_ACC, dat: cmd_i.arg1};
            end
            `CRG_OPC_ADD_IMM: begin
               arith     = {1'b0, acc_q} + {1'b0, cmd_i.arg1};
               carry_en  = 1'b1;
               carry_val = arith[8];
               wp = '{en: 1'b1, ram: 1'b0, adr: `CRG_ADR_ACC, dat: arith[7:0]};
            end
            `CRG_OPC_SUB_IMM: begin
               arith     = {1'b0, acc_q} - {1'b0, cmd_i.arg1};
               carry_en  = 1'b1;
               carry_val = arith[8];
               wp = '{en: 1'b1, ram: 1'b0, adr: `CRG_ADR_ACC, dat: arith[7:0]};
            end
            `CRG_OPC_MOV_A_RN: begin
               wp = '{en: 1'b1, ram: 1'b0, adr: `CRG_ADR_ACC,
                      dat: ram_q[bank_adr(psw_q[`CRG_PSW_RS_HI:`CRG_PSW_RS_LO],
                                          cmd_i.arg1[2:0])]};
            end
            `CRG_OPC_MOV_RN_A: begin
               wp = '{en: 1'b1, ram: 1'b1,
                      adr: bank_adr(psw_q[`CRG_PSW_RS_HI:`CRG_PSW_RS_LO], cmd_i.arg1[2:0]),
                      dat: acc_q};
            end
            `CRG_OPC_MOV_A_IND: begin
               // Indirect reads reach all of data RAM, even above the split.
               wp = '{en: 1'b1, ram: 1'b0, adr: `CRG_ADR_ACC,
                      dat: ram_q[ram_q[bank_adr(psw_q[`CRG_PSW_RS_HI:`CRG_PSW_RS_LO],
                                                {2'h0, cmd_i.arg1[0]})]]};
            end
            `CRG_OPC_MOV_IND_A: begin
               wp = '{en: 1'b1, ram: 1'b1,
                      adr: ram_q[bank_adr(psw_q[`CRG_PSW_RS_HI:`CRG_PSW_RS_LO],
                                          {2'h0, cmd_i.arg1[0]})],
                      dat: acc_q};
            end
            `CRG_OPC_MOV_A_DIR: begin
               wp = '{en: 1'b1, ram: 1'b0, adr: `CRG_ADR_ACC,
                      dat: rd_direct(cmd_i.arg1)};
            end
            `CRG_OPC_MOV_DIR_A: begin
               wp = '{en: 1'b1, ram: ~cmd_i.arg1[7], adr: cmd_i.arg1, dat: acc_q};
            end
            `CRG_OPC_SET_BIT: begin
               wp = '{en: 1'b1, ram: ~cmd_i.arg1[7], adr: bit_byte,
                      dat: bit_old | (8'h01 << cmd_i.arg1[2:0])};
            end
            `CRG_OPC_CLR_BIT: begin
               wp = '{en: 1'b1, ram: ~cmd_i.arg1[7], adr: bit_byte,
                      dat: bit_old & ~(8'h01 << cmd_i.arg1[2:0])};
            end
            `CRG_OPC_PUSH: begin
               // The byte lands at the already incremented pointer.
               wp = '{en: 1'b1, ram: 1'b1, adr: sp_q + 8'h01,
                      dat: rd_direct(cmd_i.arg1)};
            end
            default: begin
               // Idle, the unused opcode, branches and unknown codes write nothing.
               wp = '0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Program counter and branch targets.

   assign next_pc = pc_q + {14'h0000, cmd_i.len};

   // Branch target selection; everything else just steps past the command.
   always_comb begin
      case (cmd_i.opcode)
         `CRG_OPC_SHORT_JMP: target = next_pc + {{8{cmd_i.arg1[7]}}, cmd_i.arg1};
         `CRG_OPC_JMP_CARRY: target = psw_q[`CRG_PSW_CY]
                                      ? next_pc + {{8{cmd_i.arg1[7]}}, cmd_i.arg1}
                                      : next_pc;
         `CRG_OPC_PAGE_JMP:  target = {next_pc[15:11], cmd_i.arg1[2:0], cmd_i.arg2};
         `CRG_OPC_LONG_JMP:  target = {cmd_i.arg1, cmd_i.arg2};
         default:            target = next_pc;
      endcase
   end

   // The counter moves only when a command is accepted.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         pc_q <= `CRG_PC_RST;
      end else if (take) begin
         pc_q <= target;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers behind the write port.

   // Data RAM has no reset; software must initialise what it reads.
   always_ff @(posedge mclk_i) begin
      if (wp.en & wp.ram) begin
         ram_q[wp.adr] <= wp.dat;
      end
   end

   // Stack top pointer: push increments, a direct write loads.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         sp_q <= `CRG_SP_RST;
      end else if (take & ~bus_we & (cmd_i.opcode == `CRG_OPC_PUSH)) begin
         sp_q <= sp_q + 8'h01;
      end else if (wp.en & ~wp.ram & (wp.adr == `CRG_ADR_SP)) begin
         sp_q <= wp.dat;
      end
   end

   // Data pointer bytes: wide immediate loads both, direct writes one.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         dpl_q <= `CRG_DPL_RST;
         dph_q <= `CRG_DPH_RST;
      end else if (take & ~bus_we & (cmd_i.opcode == `CRG_OPC_LOAD_DATA_POINTER_WORD)) begin
         dph_q <= cmd_i.arg1;
         dpl_q <= cmd_i.arg2;
      end else if (wp.en & ~wp.ram) begin
         if (wp.adr == `CRG_ADR_DPL) begin
            dpl_q <= wp.dat;
         end
         if (wp.adr == `CRG_ADR_DPH) begin
            dph_q <= wp.dat;
         end
      end
   end

   // Both accumulators take direct and bit writes; arithmetic writes reach only the accumulator.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         acc_q <= `CRG_ACC_RST;
         b_q   <= `CRG_B_RST;
      end else if (wp.en & ~wp.ram) begin
         if (wp.adr == `CRG_ADR_ACC) begin
            acc_q <= wp.dat;
         end
         if (wp.adr == `CRG_ADR_B) begin
            b_q <= wp.dat;
         end
      end
   end

   // Status word: bit 0 is never stored, so writes there have no effect.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         psw_q <= `CRG_PSW_RST;
      end else if (wp.en & ~wp.ram & (wp.adr == `CRG_ADR_PSW)) begin
         psw_q <= wp.dat[7:1];
      end else if (carry_en) begin
         psw_q[`CRG_PSW_CY] <= carry_val;
      end
   end

   assign state_o = '{pc: pc_q, data_pointer_word: {dph_q, dpl_q}, sp: sp_q, acc: acc_q,
                      program_status_word: {psw_q, parity}};

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   logic taken_op;                       // A command other than a bus-blocked one.
   assign taken_op = take & ~bus_we;

   chk_sp_reset: assert property (@(posedge mclk_i) rst_i |=> sp_q == `CRG_SP_RST)
      else $error("stack pointer not seven after reset");
   chk_push_incr: assert property (@(posedge mclk_i) disable iff (rst_i)
      taken_op && cmd_i.opcode == `CRG_OPC_PUSH
      |=> sp_q == $past(sp_q) + 8'h01 && ram_q[sp_q] == $past(rd_direct(cmd_i.arg1)))
      else $error("push did not pre-increment");
   chk_parity_flag: assert property (@(posedge mclk_i) disable iff (rst_i)
      state_o.program_status_word[0] == ($countones(state_o.acc) % 2 == 1))
      else $error("parity flag wrong");
   chk_short_jump: assert property (@(posedge mclk_i) disable iff (rst_i)
      take && cmd_i.opcode == `CRG_OPC_SHORT_JMP
      |=> pc_q == $past(pc_q) + 16'($past(cmd_i.len)) + {{8{$past(cmd_i.arg1[7])}},
                                                           $past(cmd_i.arg1)})
      else $error("short jump target wrong");
   chk_page_jump: assert property (@(posedge mclk_i) disable iff (rst_i)
      take && cmd_i.opcode == `CRG_OPC_PAGE_JMP
      |=> pc_q[15:11] == $past(next_pc[15:11])
          && pc_q[10:0] == {$past(cmd_i.arg1[2:0]), $past(cmd_i.arg2)})
      else $error("page jump left its page");
   chk_long_jump: assert property (@(posedge mclk_i) disable iff (rst_i)
      take && cmd_i.opcode == `CRG_OPC_LONG_JMP
      |=> pc_q == {$past(cmd_i.arg1), $past(cmd_i.arg2)})
      else $error("long jump target wrong");
   chk_unused_idle: assert property (@(posedge mclk_i) disable iff (rst_i)
      taken_op && cmd_i.opcode == `CRG_OPC_UNUSED
      |=> $stable(acc_q) && $stable(sp_q) && $stable(psw_q) && $stable(dpl_q)
          && pc_q == $past(pc_q) + 16'($past(cmd_i.len)))
      else $error("unused opcode changed state");
   chk_data_pointer_word_load: assert property (@(posedge mclk_i) disable iff (rst_i)
      taken_op && cmd_i.opcode == `CRG_OPC_LOAD_DATA_POINTER_WORD
      |=> state_o.data_pointer_word == {$past(cmd_i.arg1), $past(cmd_i.arg2)})
      else $error("pointer load wrong");
   chk_carry_add: assert property (@(posedge mclk_i) disable iff (rst_i)
      taken_op && cmd_i.opcode == `CRG_OPC_ADD_IMM
      |=> psw_q[`CRG_PSW_CY] == ($past(acc_q) + 9'($past(cmd_i.arg1)) > 9'h0FF))
      else $error("carry not from addition");
   chk_psw_ro_bit: assert property (@(posedge mclk_i) disable iff (rst_i)
      bus_we && bus_idx == `CRG_ADR_PSW
      |=> psw_q == $past(wb_dat_i[7:1]) && state_o.program_status_word[0] == ^acc_q)
      else $error("status write mishandled");
   chk_bank_read: assert property (@(posedge mclk_i) disable iff (rst_i)
      taken_op && cmd_i.opcode == `CRG_OPC_MOV_A_RN
      |=> acc_q == $past(ram_q[{3'h0, psw_q[`CRG_PSW_RS_HI:`CRG_PSW_RS_LO], cmd_i.arg1[2:0]}]))
      else $error("bank register read wrong");
   chk_bus_ack: assert property (@(posedge mclk_i) disable iff (rst_i)
      bus_req && !ack_q |=> ack_q ##1 !ack_q)
      else $error("acknowledge timing wrong");

   cov_push: cover property (@(posedge mclk_i) taken_op && cmd_i.opcode == `CRG_OPC_PUSH);
   cov_carry_jump: cover property (@(posedge mclk_i)
      take && cmd_i.opcode == `CRG_OPC_JMP_CARRY && psw_q[`CRG_PSW_CY]);
   cov_bus_write: cover property (@(posedge mclk_i) bus_we && cmd_valid_i);
   cov_unused: cover property (@(posedge mclk_i) take && cmd_i.opcode == `CRG_OPC_UNUSED);

endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the core register block: bus reads, writes and commands.
// Assumes crg_pkg and crg_core_regs are compiled first, from the same folder.
`timescale 1ns/1ps
`default_nettype none
`include "crg_defines.svh"

module tb_top;
   logic                 mclk_i = 1'b0;  // Core clock, 8 ns period.
   logic                 rst_i  = 1'b1;  // Synchronous reset.
   logic                 cyc    = 1'b0;  // Shared cycle and strobe.
   logic                 we     = 1'b0;
   logic [9:0]           adr    = 10'h000;
   logic [31:0]          wdat   = 32'h0;
   logic [31:0]          wb_dat_o;
   logic                 wb_ack_o, cmd_ready_o, cv = 1'b0;
   crg_pkg::crg_cmd_type cmd    = '0;
   crg_pkg::crg_state_type st;
   logic [31:0]          q[$];           // Expected read data, oldest first.
   logic [23:0]          cq[$];          // Expected pc and accumulator per command.
   logic [23:0]          ce;             // Command note being judged.
   logic                 took   = 1'b0;  // A command was taken at the last edge.
   int                   fails = 0, comparisons = 0;
   logic [15:0]          pc = 16'h0000;  // Expected program counter.
   logic [7:0]           acc = 8'h00, v, w, a;

   always #4 mclk_i = ~mclk_i;

   crg_core_regs u_crg_core_regs (.mclk_i(mclk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmd_valid_i(cv), .cmd_i(cmd),
      .cmd_ready_o(cmd_ready_o), .state_o(st));

   ////////////////////////////////////////////////////////////////////////////////
   // Compare, report and close.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // One classic cycle; the request is held until ack is sampled, then dropped.
   task automatic wb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
      @(posedge mclk_i);
      cyc <= 1'b1;
      we <= wr;
      adr <= {idx, 2'b00};
      wdat <= {24'h0, d};
      do @(posedge mclk_i); while (wb_ack_o !== 1'b1);
      cyc <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] idx, input logic [7:0] e);
      q.push_back({24'h0, e});
      wb(1'b0, idx, 8'h00);
   endtask

   // Read data is judged by the watcher at the ack edge.
   always @(posedge mclk_i)
      if (wb_ack_o === 1'b1 && we === 1'b0 && q.size() > 0) chk(wb_dat_o, q.pop_front());

   // Offers one command and notes the pc and accumulator that must follow it.
   task automatic op(input logic [7:0] o, a1, a2, input logic [1:0] ln, input logic [15:0] np);
      pc = np;
      cq.push_back({np, acc});
      @(posedge mclk_i);
      cv <= 1'b1;
      cmd <= '{opcode: o, arg1: a1, arg2: a2, len: ln};
      do @(posedge mclk_i); while (cmd_ready_o !== 1'b1);
      cv <= 1'b0;
      #1;
   endtask

   // State is judged one edge after the edge that took the command.
   always @(posedge mclk_i) begin
      if (took === 1'b1) begin
         ce = cq.pop_front();
         chk(st.pc, ce[23:8]);
         chk(st.acc, ce[7:0]);
         chk(st.program_status_word[0], ^ce[7:0]);
      end
      took <= cv & cmd_ready_o;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      v = 8'($urandom(32'hA6DB));
      repeat (12) @(posedge mclk_i);
      rst_i <= 1'b0;
      rd(`CRG_ADR_SP, 8'h07);
      rd(`CRG_ADR_DPL, 8'h00);
      rd(`CRG_ADR_DPH, 8'h00);
      rd(`CRG_ADR_PSW, 8'h00);
      rd(`CRG_ADR_ACC, 8'h00);
      rd(`CRG_ADR_B, 8'h00);
      for (int i = 0; i < 5; i++) begin
         a = (i < 3) ? (`CRG_ADR_SP + i[7:0]) : ((i == 3) ? `CRG_ADR_ACC : `CRG_ADR_B);
         v = 8'($urandom);
         wb(1'b1, a, v);
         rd(a, v);
         if (i == 3) acc = v;
      end
      wb(1'b1, `CRG_ADR_PSW, 8'h11);
      rd(`CRG_ADR_PSW, {7'h08, ^acc});
      wb(1'b1, 8'h90, 8'h5A);
      rd(8'h90, 8'h00);
      v = {2'b01, 6'($urandom)};
      acc = v;
      op(`CRG_OPC_MOV_A_IMM, v, 8'h00, 2'd2, pc + 16'h2);
      op(`CRG_OPC_MOV_RN_A, 8'h05, 8'h00, 2'd1, pc + 16'h1);
      rd(8'h15, v);
      op(`CRG_OPC_MOV_RN_A, 8'h00, 8'h00, 2'd1, pc + 16'h1);
      w = 8'($urandom);
      acc = w;
      op(`CRG_OPC_MOV_A_IMM, w, 8'h00, 2'd2, pc + 16'h2);
      op(`CRG_OPC_MOV_IND_A, 8'h00, 8'h00, 2'd1, pc + 16'h1);
      rd(v, w);
      acc = v;
      op(`CRG_OPC_MOV_A_RN, 8'h05, 8'h00, 2'd1, pc + 16'h1);
      acc = w;
      op(`CRG_OPC_MOV_A_IND, 8'h00, 8'h00, 2'd1, pc + 16'h1);
      acc = 8'hF0;
      op(`CRG_OPC_MOV_A_IMM, 8'hF0, 8'h00, 2'd2, pc + 16'h2);
      acc = 8'h10;
      op(`CRG_OPC_ADD_IMM, 8'h20, 8'h00, 2'd2, pc + 16'h2);
      chk(st.program_status_word[7], 1'b1);
      op(`CRG_OPC_JMP_CARRY, 8'h10, 8'h00, 2'd2, pc + 16'h12);
      acc = 8'hF1;
      op(`CRG_OPC_ADD_IMM, 8'hE1, 8'h00, 2'd2, pc + 16'h2);
      chk(st.program_status_word[7], 1'b0);
      op(`CRG_OPC_JMP_CARRY, 8'h10, 8'h00, 2'd2, pc + 16'h2);
      acc = 8'hD1;
      op(`CRG_OPC_SUB_IMM, 8'h20, 8'h00, 2'd2, pc + 16'h2);
      chk(st.program_status_word[7], 1'b0);
      acc = 8'hF1;
      op(`CRG_OPC_SUB_IMM, 8'hE0, 8'h00, 2'd2, pc + 16'h2);
      chk(st.program_status_word[7], 1'b1);
      acc = 8'hD1;
      op(`CRG_OPC_ADD_IMM, 8'hE0, 8'h00, 2'd2, pc + 16'h2);
      chk(st.program_status_word[7], 1'b1);
      wb(1'b1, `CRG_ADR_SP, 8'h2F);
      op(`CRG_OPC_PUSH, `CRG_ADR_ACC, 8'h00, 2'd2, pc + 16'h2);
      rd(`CRG_ADR_SP, 8'h30);
      rd(8'h30, 8'hD1);
      acc = 8'hF1;
      op(`CRG_OPC_SET_BIT, 8'hE5, 8'h00, 2'd2, pc + 16'h2);
      acc = 8'hD1;
      op(`CRG_OPC_CLR_BIT, 8'hE5, 8'h00, 2'd2, pc + 16'h2);
      wb(1'b1, 8'h23, 8'h00);
      op(`CRG_OPC_SET_BIT, 8'h1B, 8'h00, 2'd2, pc + 16'h2);
      rd(8'h23, 8'h08);
      op(`CRG_OPC_LOAD_DATA_POINTER_WORD, 8'hA7, 8'h3C, 2'd3, pc + 16'h3);
      chk(st.data_pointer_word, 16'hA73C);
      rd(`CRG_ADR_DPL, 8'h3C);
      rd(`CRG_ADR_DPH, 8'hA7);
      acc = 8'h3C;
      op(`CRG_OPC_MOV_A_DIR, `CRG_ADR_DPL, 8'h00, 2'd2, pc + 16'h2);
      op(`CRG_OPC_MOV_DIR_A, 8'h40, 8'h00, 2'd2, pc + 16'h2);
      rd(8'h40, 8'h3C);
      // A command offered while a bus write lands waits one cycle.
      acc = 8'h77;
      fork
         wb(1'b1, 8'h60, 8'hC3);
         begin
            @(posedge mclk_i);
            op(`CRG_OPC_MOV_A_IMM, 8'h77, 8'h00, 2'd2, pc + 16'h2);
         end
      join
      rd(8'h60, 8'hC3);
      op(`CRG_OPC_SHORT_JMP, 8'hF0, 8'h00, 2'd2, pc + 16'h2 - 16'h10);
      op(`CRG_OPC_LONG_JMP, 8'h17, 8'hFE, 2'd3, 16'h17FE);
      op(`CRG_OPC_PAGE_JMP, 8'h03, 8'h45, 2'd2, 16'h1B45);
      op(`CRG_OPC_UNUSED, 8'h00, 8'h00, 2'd1, pc + 16'h1);
      op(`CRG_OPC_IDLE, 8'h00, 8'h00, 2'd1, pc + 16'h1);
      repeat (3) @(posedge mclk_i);
      chk(q.size(), 0);
      chk(cq.size(), 0);
      end_of_test();
   end

   // Watchdog: the sequence needs well under 2,000 cycles.
   initial begin
      #40000;
      fails++;
      end_of_test();
   end
endmodule
`default_nettype wire
